/* File: logic/flash_protect_pkg.sv */
// Purpose: shared constants for the serial flash write-protection block
// Assumes: 64K-byte blocks, 128 blocks, 24-bit byte addresses
// Notes: command codes are plain defaults of the serial command set
package flash_protect_pkg;
  localparam int ADDR_W = 24;
  localparam int BLOCK_LSB = 16;              // 64K-byte block number starts here
  localparam int BLOCK_W = 7;                 // 128 blocks
  localparam logic [6:0] TOP_BLOCK = 7'h7f;   // block 127
  localparam logic [9:0] OTP_ROW_SPLIT = 10'h200; // 000-1ff customer, 200-3ff factory
  localparam int OTP_ADDR_W = 10;
  // command codes
  localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_BE32 = 8'h52;
  localparam logic [7:0] CMD_BE64 = 8'hd8;
  localparam logic [7:0] CMD_CE = 8'hc7;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
  localparam logic [7:0] CMD_RDP = 8'hab;
  localparam logic [7:0] CMD_OTP_ENTER = 8'hb1;
  localparam logic [7:0] CMD_OTP_EXIT = 8'hc1;
  localparam logic [7:0] CMD_SEC_LOCK = 8'h2f;
  // status byte field positions
  localparam int SR_TB_SET = 1; // one-way top/bottom set bit
  localparam int SR_BP_LSB = 2;
  localparam int SR_SRWD = 7;
  // security register field positions
  localparam int SCUR_FACTORY_LOCK = 0;
  localparam int SCUR_CUSTOMER_LOCK = 1;
  // reset values
  localparam logic [3:0] BP_RESET = 4'h0;
  localparam logic TB_RESET = 1'b0;
  // command decoder states
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_OPCODE  = 2'b01,
    ST_ARGS    = 2'b10,
    ST_SLEEP   = 2'b11
  } cmd_state_t;
endpackage

/* File: logic/flash_write_protect.sv */
// Purpose: write-protection and OTP lock gate of a serial NOR flash
// Assumes: link pins sampled by clk; only single-line command entry decoded here
// Notes: emits one-cycle grant pulses for program and erase, reject pulses for program, erase, status writes and security lock
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module flash_write_protect #(
  parameter logic FACTORY_LOCKED = 1'b0 // factory lock strap, value arbitrary
) (
  input wire logic clk,                                  // system clock 50 MHz
  input wire logic reset_n,                              // async reset, active low
  input wire logic clkEn,                                // freezes all state when low
  input wire logic chipSelectN,                          // link chip select, active low
  input wire logic serialClk,                            // link serial clock
  input wire logic serial_in_or_data_line_0,             // data line 0 in
  input wire logic write_protect_or_data_line_2,         // write protect pin in
  input wire logic hw_reset_or_data_line_3,              // reset pin in
  input wire logic quadEnable,                           // four-line data mode bit
  input wire logic four_line_command_mode,               // four-line command mode
  output logic [3:0] blockProtect,                       // protect bits, registered
  output logic topBottom,                                // top/bottom bit, registered
  output logic srwd,                                     // status write protect bit
  output logic write_enable_latch,                       // write enable latch
  output logic [7:0] securityReg,                        // security register view
  output logic otpMode,                                  // OTP mode active
  output logic deep_power_down,                          // deep power-down active
  output logic hardware_protected_mode,                  // pin guard in effect
  output logic writeGrant,                               // pulse: array/OTP write allowed
  output logic writeReject,                              // pulse: data-changing cmd refused
  output logic [flash_protect_pkg::ADDR_W-1:0] writeAddr // target address of last ended command
);
  import flash_protect_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] csSync_q, sclkSync_q, siSync_q, wpSync_q, rstSync_q;
  // two flops per pin before any logic reads it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csSync_q <= 2'h3;
      sclkSync_q <= 2'h0;
      siSync_q <= 2'h0;
      wpSync_q <= 2'h3;
      rstSync_q <= 2'h3;
    end else if (clkEn) begin
      csSync_q <= {csSync_q[0], chipSelectN};
      sclkSync_q <= {sclkSync_q[0], serialClk};
      siSync_q <= {siSync_q[0], serial_in_or_data_line_0};
      wpSync_q <= {wpSync_q[0], write_protect_or_data_line_2};
      rstSync_q <= {rstSync_q[0], hw_reset_or_data_line_3};
    end
  end

  logic csN, sclkPrev_q, csPrev_q, sclkRise, csRise, csFall, fourLine, hwResetActive;
  assign csN = csSync_q[1];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclkPrev_q <= sclkSync_q[1];
      csPrev_q <= csN;
    end
  end
  assign sclkRise = sclkSync_q[1] & ~sclkPrev_q & ~csN;
  assign csRise = csN & ~csPrev_q;
  assign csFall = ~csN & csPrev_q;
  assign fourLine = quadEnable | four_line_command_mode;
  // shared pin acts as reset only outside four-line mode
  assign hwResetActive = ~rstSync_q[1] & ~fourLine;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // block-protect decode: is this 64K block inside the read-only region
  function automatic logic blockProtected(input logic [3:0] bp, input logic tb,
                                          input logic [BLOCK_W-1:0] blk);
    logic [BLOCK_W:0] count;
    count = 8'h00;
    if (bp[3]) begin
      blockProtected = 1'b1;
    end else if (bp[2:0] == 3'h0) begin
      blockProtected = 1'b0;
    end else begin
      count = 8'h01 << (bp[2:0] - 3'h1);
      if (tb) begin
        blockProtected = ({1'b0, blk} < count);
      end else begin
        blockProtected = ({1'b0, TOP_BLOCK - blk} < count);
      end
    end
  endfunction

  function automatic logic isChange(input logic [7:0] op);
    isChange = (op == CMD_PP) || (op == CMD_SE) || (op == CMD_BE32) || (op == CMD_BE64) ||
               (op == CMD_CE) || (op == CMD_WRSR) || (op == CMD_SEC_LOCK);
  endfunction

  function automatic logic needsAddr(input logic [7:0] op);
    needsAddr = (op == CMD_PP) || (op == CMD_SE) || (op == CMD_BE32) || (op == CMD_BE64);
  endfunction

  // ----------------------------------------------------------------
  // command shifter
  // ----------------------------------------------------------------
  cmd_state_t state_q;
  logic [2:0] bitCnt_q;
  logic [5:0] byteCnt_q;
  logic [7:0] shift_q, opcode_q, arg0_q;
  logic [ADDR_W-1:0] addr_q;
  logic byteDone;
  assign byteDone = sclkRise && (bitCnt_q == 3'h7);

  // state machine starts in standby and sleeps in deep power-down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_STANDBY;
    end else if (clkEn) begin
      if (hwResetActive) begin
        state_q <= ST_STANDBY;
      end else begin
        case (state_q)
          ST_STANDBY: begin
            if (csFall) begin
              state_q <= ST_OPCODE;
            end
          end
          ST_OPCODE: begin
            if (csRise) begin
              state_q <= ST_STANDBY;
            end else if (byteDone) begin
              state_q <= ST_ARGS;
            end
          end
          ST_ARGS: begin
            if (csRise) begin
              state_q <= (opcode_q == CMD_POWER_DOWN) && (bitCnt_q == 3'h0) && (byteCnt_q == 6'h1)
                         ? ST_SLEEP : ST_STANDBY;
            end
          end
          ST_SLEEP: begin
            // a chip-select pulse or the reset pin wakes the device
            if (csRise) begin
              state_q <= ST_STANDBY;
            end
          end
          default: state_q <= ST_STANDBY;
        endcase
      end
    end
  end

  // bit and byte counters plus shifter; counters cleared and shifter held while asleep
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_q <= 3'h0;
      byteCnt_q <= 6'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      arg0_q <= 8'h00;
      addr_q <= '0;
    end else if (clkEn) begin
      if (csFall || state_q == ST_SLEEP || state_q == ST_STANDBY) begin
        bitCnt_q <= 3'h0;
        byteCnt_q <= 6'h0;
      end else if (sclkRise) begin
        bitCnt_q <= bitCnt_q + 3'h1;
        shift_q <= {shift_q[6:0], siSync_q[1]};
        if (bitCnt_q == 3'h7) begin
          if (byteCnt_q != 6'h3f) begin
            byteCnt_q <= byteCnt_q + 6'h1;
          end
          if (byteCnt_q == 6'h0) begin
            opcode_q <= {shift_q[6:0], siSync_q[1]};
          end
          if (byteCnt_q == 6'h1) begin
            arg0_q <= {shift_q[6:0], siSync_q[1]};
          end
          if (byteCnt_q >= 6'h1 && byteCnt_q <= 6'h3) begin
            addr_q <= {addr_q[ADDR_W-9:0], shift_q[6:0], siSync_q[1]};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command completion and protection checks
  // ----------------------------------------------------------------
  logic endCmd, wholeBytes, hwGuard, targetProt, otpRowLocked, allow;
  assign endCmd = csRise && (state_q == ST_ARGS) && !hwResetActive;
  assign wholeBytes = (bitCnt_q == 3'h0);
  assign hwGuard = ~wpSync_q[1] & ~fourLine;
  // factory row lives at 200-3ff, customer row at 000-1ff
  assign otpRowLocked = (addr_q[OTP_ADDR_W-1:0] >= OTP_ROW_SPLIT) ? securityReg[SCUR_FACTORY_LOCK]
                        : securityReg[SCUR_CUSTOMER_LOCK];

  always_comb begin
    targetProt = 1'b0;
    if (opcode_q == CMD_CE) begin
      targetProt = (blockProtect != 4'h0) || otpMode;
    end else if (needsAddr(opcode_q)) begin
      if (otpMode) begin
        // OTP mode only programs OTP rows, never erases the main array
        targetProt = (opcode_q != CMD_PP) || otpRowLocked;
      end else begin
        targetProt = blockProtected(blockProtect, topBottom,
                                    addr_q[BLOCK_LSB +: BLOCK_W]);
      end
    end else if (opcode_q == CMD_WRSR) begin
      targetProt = srwd && hwGuard;
    end
  end
  assign allow = wholeBytes && write_enable_latch && !targetProt &&
                 (!needsAddr(opcode_q) || byteCnt_q >= 6'h4);

  // write enable latch: set by its command, cleared after any whole-byte data change command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_enable_latch <= 1'b0;
    end else if (clkEn) begin
      if (hwResetActive) begin
        write_enable_latch <= 1'b0;
      end else if (endCmd && wholeBytes && byteCnt_q == 6'h1 && opcode_q == CMD_WR_ENABLE) begin
        write_enable_latch <= 1'b1;
      end else if (endCmd && wholeBytes && byteCnt_q == 6'h1 && opcode_q == CMD_WRDI) begin
        write_enable_latch <= 1'b0;
      end else if (endCmd && isChange(opcode_q) && wholeBytes) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // status fields; the pin guard freezes the protect bits and srwd
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blockProtect <= BP_RESET;
      topBottom <= TB_RESET;
      srwd <= 1'b0;
    end else if (clkEn) begin
      if (endCmd && opcode_q == CMD_WRSR && allow && byteCnt_q >= 6'h2) begin
        blockProtect <= arg0_q[SR_BP_LSB +: 4];
        srwd <= arg0_q[SR_SRWD];
        topBottom <= topBottom | arg0_q[SR_TB_SET]; // one-way, once set stays set
      end
    end
  end

  // security register: factory lock strap caught after release, customer lock one-way
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      securityReg <= 8'h00;
    end else if (clkEn) begin
      securityReg[SCUR_FACTORY_LOCK] <= FACTORY_LOCKED;
      if (endCmd && opcode_q == CMD_SEC_LOCK && allow) begin
        securityReg[SCUR_CUSTOMER_LOCK] <= 1'b1;
      end
    end
  end

  // OTP mode entry and exit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      otpMode <= 1'b0;
    end else if (clkEn) begin
      if (hwResetActive) begin
        otpMode <= 1'b0;
      end else if (endCmd && wholeBytes && opcode_q == CMD_OTP_ENTER) begin
        otpMode <= 1'b1;
      end else if (endCmd && wholeBytes && opcode_q == CMD_OTP_EXIT) begin
        otpMode <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // verdict pulses; a cut final byte ends silently with the latch kept
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      writeGrant <= 1'b0;
      writeReject <= 1'b0;
    end else if (clkEn) begin
      writeGrant <= endCmd && isChange(opcode_q) && allow && opcode_q != CMD_WRSR &&
                    opcode_q != CMD_SEC_LOCK;
      writeReject <= endCmd && wholeBytes && isChange(opcode_q) && !allow;
    end
  end

  // target address of the last ended command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      writeAddr <= '0;
    end else if (clkEn && endCmd) begin
      writeAddr <= addr_q;
    end
  end

  // sleep flag mirrors the decoder state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deep_power_down <= 1'b0;
    end else if (clkEn) begin
      deep_power_down <= (state_q == ST_SLEEP);
    end
  end

  // pin guard flag: pin low and guard bit set, never in four-line mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hardware_protected_mode <= 1'b0;
    end else if (clkEn) begin
      hardware_protected_mode <= hwGuard && srwd;
    end
  end
endmodule
`default_nettype wire

/* File: verif/flash_write_protect_asserts.sv */
// Purpose: port checker for the write-protection gate
// Assumes: one clock domain, reset_n active low
// Notes: verdict pulses follow the select rise by a few cycles
`timescale 1ns/1ns
`default_nettype none
module flash_write_protect_asserts #(
  parameter logic FACTORY_LOCKED = 1'b0 // factory strap, value arbitrary
) (
  input wire logic clk, // clock
  input wire logic reset_n, // reset, active low
  input wire logic clkEn, // run enable
  input wire logic quadEnable, // four-line data mode
  input wire logic four_line_command_mode, // four-line command mode
  input wire logic hw_reset_or_data_line_3, // reset pin
  input wire logic [3:0] blockProtect, // protect bits
  input wire logic srwd, // status guard bit
  input wire logic write_enable_latch, // enable latch
  input wire logic [7:0] securityReg, // security bits
  input wire logic otpMode, // otp mode
  input wire logic deep_power_down, // sleep
  input wire logic hardware_protected_mode, // pin guard
  input wire logic writeGrant, // grant pulse
  input wire logic writeReject // reject pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // reset lands in standby with nothing armed
  standby_start_a: assert property ($rose(reset_n) |-> !write_enable_latch && !otpMode && !deep_power_down)
    else $error("state not idle after reset");
  one_verdict_a: assert property (!(writeGrant && writeReject))
    else $error("grant and reject together");
  grant_latch_a: assert property (writeGrant |-> $past(write_enable_latch) || $past(write_enable_latch, 2))
    else $error("grant without enable latch");
  pulse_once_a: assert property ((writeGrant || writeReject) |=> !writeGrant && !writeReject)
    else $error("verdict pulse too long");
  latch_drop_a: assert property ((writeGrant || writeReject) |-> ##[0:1] !write_enable_latch)
    else $error("latch kept after verdict");
  sleep_nogrant_a: assert property (deep_power_down |-> !writeGrant)
    else $error("grant while asleep");
  sleep_frozen_a: assert property (deep_power_down && $past(deep_power_down) |-> $stable(blockProtect)
    && $stable(write_enable_latch))
    else $error("state changed while asleep");
  pin_guard_a: assert property (hardware_protected_mode && $past(hardware_protected_mode)
    |-> $stable(blockProtect) && $stable(srwd))
    else $error("guarded bits changed");
  quad_noguard_a: assert property ((quadEnable || four_line_command_mode) [*2] |-> !hardware_protected_mode)
    else $error("pin guard in four-line mode");
  factory_bit_a: assert property ($past(reset_n) && $past(clkEn) |-> securityReg[0] == FACTORY_LOCKED)
    else $error("factory lock bit wrong");
  lock_sticks_a: assert property (securityReg[1] |=> securityReg[1])
    else $error("customer lock cleared");
  pin_reset_a: assert property ((!hw_reset_or_data_line_3 && !quadEnable && !four_line_command_mode) [*4]
    |-> !write_enable_latch)
    else $error("reset pin ignored");
  // main scenarios reached
  grant_c: cover property (writeGrant);
  reject_c: cover property (writeReject);
  sleep_c: cover property (deep_power_down);
  otp_c: cover property (otpMode);
endmodule
`default_nettype wire

/* File: verif/flash_host_model.sv */
// Purpose: host side of the serial link
// Assumes: mode 0 link, msb first, 160 ns link clock
// Notes: link clock stands low between frames
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  input wire logic clk, // system clock
  output logic chipSelectN, // select, active low
  output logic serialClk, // link clock
  output logic dataLine0 // command line
);
  // idle link at time zero
  initial begin
    chipSelectN = 1'b1;
    serialClk = 1'b0;
    dataLine0 = 1'b0;
  end
  // one frame of n bits; callers pass whole bytes unless testing a cut frame
  task automatic send(input logic [31:0] v, input int n);
    int i;
    @(posedge clk) chipSelectN <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = n - 1; i >= 0; i--) begin
      dataLine0 <= v[i];
      repeat (4) @(posedge clk);
      serialClk <= 1'b1;
      repeat (4) @(posedge clk);
      serialClk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chipSelectN <= 1'b1;
    dataLine0 <= ~dataLine0; // released line shows no stale bit
    repeat (16) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: verif/flash_write_protect_tb.sv */
// Purpose: self-checking bench for the write-protection gate
// Assumes: host model drives the link, bench drives pins
// Notes: verdict pulses are counted and compared per command
`timescale 1ns/1ns
`default_nettype none
module flash_write_protect_tb;
  import flash_protect_pkg::*;
  localparam logic FACTORY_LOCKED = 1'b0; // strap, value arbitrary
  logic clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, wpN = 1'b1, hwRstN = 1'b1, quadEn = 1'b0, quadCmd = 1'b0;
  logic csN, sck, d0, tbit, sw, latchOn, otp, sleeping, pinGuard, grant, reject;
  logic [3:0] bp;
  logic [7:0] scur;
  logic [23:0] waddr;
  int bad_count = 0, n_compared = 0, gCnt = 0, rCnt = 0, cyc = 0;
  always #10 clk = ~clk;
  flash_write_protect #(.FACTORY_LOCKED(FACTORY_LOCKED)) dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .chipSelectN(csN), .serialClk(sck), .serial_in_or_data_line_0(d0), .write_protect_or_data_line_2(wpN),
    .hw_reset_or_data_line_3(hwRstN), .quadEnable(quadEn), .four_line_command_mode(quadCmd), .blockProtect(bp),
    .topBottom(tbit), .srwd(sw), .write_enable_latch(latchOn), .securityReg(scur), .otpMode(otp),
    .deep_power_down(sleeping), .hardware_protected_mode(pinGuard), .writeGrant(grant), .writeReject(reject),
    .writeAddr(waddr));
  flash_host_model host (.clk(clk), .chipSelectN(csN), .serialClk(sck), .dataLine0(d0));
  // verdict pulse counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (grant === 1'b1) gCnt <= gCnt + 1;
    if (reject === 1'b1) rCnt <= rCnt + 1;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // optional enable, one command, then compare grant and reject counts
  task automatic op(input bit pre, input logic [31:0] v, input int n, input int eg, input int er);
    int g0, r0;
    g0 = gCnt;
    r0 = rCnt;
    if (pre) host.send({24'h0, CMD_WR_ENABLE}, 8);
    host.send(v, n);
    check(gCnt - g0, eg);
    check(rCnt - r0, er);
  endtask
  // enabled status write: guard bit, protect code, top/bottom
  task automatic sr(input logic [3:0] b, input logic t, input logic s);
    host.send({24'h0, CMD_WR_ENABLE}, 8);
    host.send({16'h0, CMD_WRSR, s, 1'b0, b, t, 1'b0}, 16);
  endtask
  initial begin
    int n, blk;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    check({latchOn, otp, sleeping, grant, reject}, 5'h0);
    check(scur[0], FACTORY_LOCKED);
    op(0, {CMD_PP, 24'h000100}, 32, 0, 1);
    host.send({24'h0, CMD_WR_ENABLE} >> 1, 7);
    check(latchOn, 1'b0);
    op(1, {CMD_PP, 24'h000100} >> 1, 31, 0, 0);
    check(latchOn, 1'b1);
    // upper protected region: last protected and first free block
    for (n = 1; n <= 7; n++) begin
      sr(4'(n), 1'b0, 1'b0);
      blk = 128 - (1 << (n - 1));
      check(bp, 4'(n));
      op(1, {CMD_SE, 1'b0, 7'(blk), 16'h0}, 32, 0, 1);
      check(latchOn, 1'b0);
      op(1, {CMD_SE, 1'b0, 7'(blk - 1), 16'h0}, 32, 1, 0);
      check(waddr, {1'b0, 7'(blk - 1), 16'h0});
    end
    op(1, {24'h0, CMD_CE}, 8, 0, 1);
    sr(4'h8, 1'b0, 1'b0);
    op(1, {CMD_SE, 24'h000000}, 32, 0, 1);
    sr(4'h0, 1'b0, 1'b0);
    op(1, {24'h0, CMD_CE}, 8, 1, 0);
    // lower protected region
    for (n = 1; n <= 7; n++) begin
      sr(4'(n), 1'b1, 1'b0);
      blk = 1 << (n - 1);
      check(tbit, 1'b1);
      op(1, {CMD_SE, 1'b0, 7'(blk - 1), 16'h0}, 32, 0, 1);
      op(1, {CMD_SE, 1'b0, 7'(blk), 16'h0}, 32, 1, 0);
    end
    // otp area with the whole array protected
    sr(4'hf, 1'b1, 1'b0);
    host.send({24'h0, CMD_OTP_ENTER}, 8);
    check(otp, 1'b1);
    op(1, {CMD_PP, 24'h000010}, 32, 1, 0);
    op(1, {CMD_SE, 24'h000000}, 32, 0, 1);
    host.send({24'h0, CMD_WR_ENABLE}, 8);
    host.send({24'h0, CMD_SEC_LOCK}, 8);
    check(scur[1], 1'b1);
    op(1, {CMD_PP, 24'h000010}, 32, 0, 1);
    op(1, {CMD_PP, 24'h000200}, 32, 1, 0);
    host.send({24'h0, CMD_OTP_EXIT}, 8);
    check(otp, 1'b0);
    // pin guard, then four-line modes lift it
    sr(4'h0, 1'b1, 1'b1);
    wpN <= 1'b0;
    repeat (4) @(posedge clk);
    check({sw, pinGuard}, 2'h3);
    op(1, {16'h0, CMD_WRSR, 8'h8e}, 16, 0, 1);
    check(bp, 4'h0);
    quadEn <= 1'b1;
    repeat (4) @(posedge clk);
    check(pinGuard, 1'b0);
    sr(4'h3, 1'b1, 1'b1);
    check(bp, 4'h3);
    quadEn <= 1'b0;
    quadCmd <= 1'b1;
    repeat (4) @(posedge clk);
    check(pinGuard, 1'b0);
    quadCmd <= 1'b0;
    wpN <= 1'b1;
    // sleep ignores commands until a select pulse
    host.send({24'h0, CMD_POWER_DOWN}, 8);
    check(sleeping, 1'b1);
    host.send({24'h0, CMD_WR_ENABLE}, 8);
    check(latchOn, 1'b0);
    host.send(32'h0, 0);
    check(sleeping, 1'b0);
    // reset pin clears the latch
    host.send({24'h0, CMD_WR_ENABLE}, 8);
    check(latchOn, 1'b1);
    hwRstN <= 1'b0;
    repeat (6) @(posedge clk);
    hwRstN <= 1'b1;
    repeat (6) @(posedge clk);
    check(latchOn, 1'b0);
    // a low clock enable freezes the block, so a whole command goes unseen
    clkEn <= 1'b0;
    host.send({24'h0, CMD_WR_ENABLE}, 8);
    check(latchOn, 1'b0);
    clkEn <= 1'b1;
    host.send({24'h0, CMD_WR_ENABLE}, 8);
    check(latchOn, 1'b1);
    end_sim();
  end
endmodule
bind flash_write_protect flash_write_protect_asserts #(.FACTORY_LOCKED(FACTORY_LOCKED)) chk (.clk(clk),
  .reset_n(reset_n), .clkEn(clkEn), .quadEnable(quadEnable), .four_line_command_mode(four_line_command_mode),
  .hw_reset_or_data_line_3(hw_reset_or_data_line_3), .blockProtect(blockProtect), .srwd(srwd),
  .write_enable_latch(write_enable_latch), .securityReg(securityReg), .otpMode(otpMode),
  .deep_power_down(deep_power_down), .hardware_protected_mode(hardware_protected_mode),
  .writeGrant(writeGrant), .writeReject(writeReject));
`default_nettype wire
